/* hw/tglc_pkg.sv */
package tglc_pkg;

  // ==========================================================================
  // Register map, word indices (byte address is four times the index).
  localparam logic [7:0] REG_SPLIT_IDX   = 8'h20;
  localparam logic [7:0] REG_PRIMARY_IDX = 8'h21;
  localparam logic [7:0] REG_LED_IDX     = 8'h22;
  localparam logic [7:0] REG_RANGE_IDX   = 8'h23;
  localparam int         ADDR_W          = 10;

  // ==========================================================================
  // Field positions.
  localparam int SEP_EN_BIT   = 15;
  localparam int CAP_LSB      = 3;
  localparam int RES_LSB      = 0;
  localparam int SEL_W        = 3;
  localparam int PULSE_EN_BIT = 8;
  localparam int LED1_LSB     = 0;
  localparam int LED2_LSB     = 6;
  localparam int LED3_LSB     = 12;
  localparam int LED_W        = 6;
  localparam int RANGE_BIT    = 17;

  // ==========================================================================
  // Reset values and writable masks.
  localparam logic [23:0] REG_RESET     = 24'h000000;
  localparam logic [23:0] SPLIT_MASK    = 24'h00803F;
  localparam logic [23:0] PRIMARY_MASK  = 24'h00003F;
  localparam logic [23:0] LED_MASK      = 24'h03FFFF;
  localparam logic [23:0] RANGE_MASK    = 24'h020000;

  // ==========================================================================
  // Decoded analog values.
  localparam logic [15:0] LED_STEP_UA   = 16'h0320;
  localparam logic [5:0]  LED_MAX_CODE  = 6'h3F;
  localparam logic [15:0] LED_FULL_UA   = 16'hC350;

  typedef enum logic [1:0] {
    TGLC_IDLE = 2'b00,
    TGLC_ACK  = 2'b01
  } tglc_state_t;

endpackage

/* hw/tglc_regs.sv */
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
// What this block does
// - Bit 15 of the split register chooses one shared gain set or two separate sets.
// - In separate mode bits 5-3 of the split register pick the second capacitor code.
// - In separate mode bits 2-0 of the split register pick the second resistor code.
// - Bits 5-3 of the primary register drive both capacitors when shared, else the first.
// - Bits 2-0 of the primary register drive both resistors when shared, else the first.
// - Resistor codes 0..7 mean 500k, 250k, 100k, 50k, 25k, 10k, 1M and 2M ohms.
// - Capacitor codes 0..7 mean 5, 2.5, 10, 7.5, 20, 17.5, 25 and 22.5 pF.
// - Write-only bit 8 of the primary register swaps the done pin for the timing pulse.
// - The LED register holds LED3 in bits 17-12, LED2 in 11-6 and LED1 in 5-0.
// - Each LED code maps linearly, 0.8 mA a step, with code 63 at 50 mA.
// - The range-double bit makes full scale 100 mA, doubling every step.
module tglc_regs (
  // Clock and reset.
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_n_i,
  // Wishbone slave.
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [tglc_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // Timing signals for the done pin.
  input  wire logic                     conv_done_i,
  input  wire logic                     prog_pulse_i,
  // Amplifier and LED controls.
  output logic                          conv_done_pin_o,
  output logic      [2:0]               res1_sel_o,
  output logic      [2:0]               res2_sel_o,
  output logic      [2:0]               cap1_sel_o,
  output logic      [2:0]               cap2_sel_o,
  output logic      [20:0]              res1_ohm_o,
  output logic      [9:0]               cap1_tenth_pf_o,
  output logic      [16:0]              led1_ua_o,
  output logic      [16:0]              led2_ua_o,
  output logic      [16:0]              led3_ua_o
);

  // ==========================================================================
  // Decoding functions.
  function automatic logic [20:0] res_ohm(input logic [2:0] c);
    case (c)
      3'h0: res_ohm = 21'h07A120;
      3'h1: res_ohm = 21'h03D090;
      3'h2: res_ohm = 21'h0186A0;
      3'h3: res_ohm = 21'h00C350;
      3'h4: res_ohm = 21'h0061A8;
      3'h5: res_ohm = 21'h002710;
      3'h6: res_ohm = 21'h0F4240;
      default: res_ohm = 21'h1E8480;
    endcase
  endfunction

  function automatic logic [9:0] cap_tenth(input logic [2:0] c);
    case (c)
      3'h0: cap_tenth = 10'h032;
      3'h1: cap_tenth = 10'h019;
      3'h2: cap_tenth = 10'h064;
      3'h3: cap_tenth = 10'h04B;
      3'h4: cap_tenth = 10'h0C8;
      3'h5: cap_tenth = 10'h0AF;
      3'h6: cap_tenth = 10'h0FA;
      default: cap_tenth = 10'h0E1;
    endcase
  endfunction

  function automatic logic [16:0] led_ua(input logic [5:0] c, input logic dbl);
    logic [15:0] base;
    base = (c == tglc_pkg::LED_MAX_CODE) ? tglc_pkg::LED_FULL_UA
         : 16'(c * tglc_pkg::LED_STEP_UA);
    led_ua = dbl ? {base, 1'b0} : {1'b0, base};
  endfunction

  // ==========================================================================
  // Bus decode.
  logic [23:0] split_r, primary_r, led_r, range_r;
  logic        pulse_en_r;
  logic        ack_r;
  logic [31:0] dat_r;
  wire  [7:0]  idx      = wb_adr_i[tglc_pkg::ADDR_W-1:2];
  wire         req      = wb_cyc_i && wb_stb_i && !ack_r;
  wire         wr       = req && wb_we_i;
  wire  [23:0] be_mask  = {{8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire         hit_split   = (idx == tglc_pkg::REG_SPLIT_IDX);
  wire         hit_primary = (idx == tglc_pkg::REG_PRIMARY_IDX);
  wire         hit_led     = (idx == tglc_pkg::REG_LED_IDX);
  wire         hit_range   = (idx == tglc_pkg::REG_RANGE_IDX);

  function automatic logic [23:0] merge(input logic [23:0] old, input logic [23:0] m);
    merge = ((old & ~be_mask) | (wb_dat_i[23:0] & be_mask)) & m;
  endfunction

  wire [23:0] split_nxt   = (wr && hit_split)   ? merge(split_r, tglc_pkg::SPLIT_MASK) : split_r;
  wire [23:0] primary_nxt = (wr && hit_primary) ? merge(primary_r, tglc_pkg::PRIMARY_MASK)
                                                : primary_r;
  wire [23:0] led_nxt     = (wr && hit_led)     ? merge(led_r, tglc_pkg::LED_MASK) : led_r;
  wire [23:0] range_nxt   = (wr && hit_range)   ? merge(range_r, tglc_pkg::RANGE_MASK) : range_r;
  wire        pulse_en_nxt = (wr && hit_primary && wb_sel_i[1])
                           ? wb_dat_i[tglc_pkg::PULSE_EN_BIT] : pulse_en_r;
  wire [23:0] rd_word = hit_split   ? split_r
                      : hit_primary ? primary_r
                      : hit_led     ? led_r
                      : hit_range   ? range_r : 24'h000000;

  // ==========================================================================
  // Field selection.
  wire       sep_en  = split_r[tglc_pkg::SEP_EN_BIT];
  wire [2:0] cap1    = primary_r[tglc_pkg::CAP_LSB +: tglc_pkg::SEL_W];
  wire [2:0] res1    = primary_r[tglc_pkg::RES_LSB +: tglc_pkg::SEL_W];
  wire [2:0] cap2    = sep_en ? split_r[tglc_pkg::CAP_LSB +: tglc_pkg::SEL_W] : cap1;
  wire [2:0] res2    = sep_en ? split_r[tglc_pkg::RES_LSB +: tglc_pkg::SEL_W] : res1;
  wire       dbl     = range_r[tglc_pkg::RANGE_BIT];
  wire [5:0] led1    = led_r[tglc_pkg::LED1_LSB +: tglc_pkg::LED_W];
  wire [5:0] led2    = led_r[tglc_pkg::LED2_LSB +: tglc_pkg::LED_W];
  wire [5:0] led3    = led_r[tglc_pkg::LED3_LSB +: tglc_pkg::LED_W];
  wire       pin_nxt = pulse_en_r ? prog_pulse_i : conv_done_i;

  // ==========================================================================
  // Registers.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      split_r    <= tglc_pkg::REG_RESET;
      primary_r  <= tglc_pkg::REG_RESET;
      led_r      <= tglc_pkg::REG_RESET;
      range_r    <= tglc_pkg::REG_RESET;
      pulse_en_r <= 1'b0;
      ack_r      <= 1'b0;
      dat_r      <= 32'h00000000;
    end else begin
      split_r    <= split_nxt;
      primary_r  <= primary_nxt;
      led_r      <= led_nxt;
      range_r    <= range_nxt;
      pulse_en_r <= pulse_en_nxt;
      ack_r      <= req;
      dat_r      <= (req && !wb_we_i) ? {8'h00, rd_word} : 32'h00000000;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_done_pin_o <= 1'b0;
      res1_sel_o      <= 3'h0;
      res2_sel_o      <= 3'h0;
      cap1_sel_o      <= 3'h0;
      cap2_sel_o      <= 3'h0;
      res1_ohm_o      <= 21'h07A120;
      cap1_tenth_pf_o <= 10'h032;
      led1_ua_o       <= 17'h00000;
      led2_ua_o       <= 17'h00000;
      led3_ua_o       <= 17'h00000;
    end else begin
      conv_done_pin_o <= pin_nxt;
      res1_sel_o      <= res1;
      res2_sel_o      <= res2;
      cap1_sel_o      <= cap1;
      cap2_sel_o      <= cap2;
      res1_ohm_o      <= res_ohm(res1);
      cap1_tenth_pf_o <= cap_tenth(cap1);
      led1_ua_o       <= led_ua(led1, dbl);
      led2_ua_o       <= led_ua(led2, dbl);
      led3_ua_o       <= led_ua(led3, dbl);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ==========================================================================
  // Assertions.
  property p_sep_res;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !split_r[tglc_pkg::SEP_EN_BIT] |=> (res2_sel_o == res1_sel_o);
  endproperty
  a_sep_res: assert property (p_sep_res) else $error("Shared mode resistor mismatch.");

  property p_sep_cap;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      split_r[tglc_pkg::SEP_EN_BIT] |=> (cap2_sel_o == $past(split_r[5:3]));
  endproperty
  a_sep_cap: assert property (p_sep_cap) else $error("Second capacitor wrong.");

  property p_res2;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      split_r[tglc_pkg::SEP_EN_BIT] |=> (res2_sel_o == $past(split_r[2:0]));
  endproperty
  a_res2: assert property (p_res2) else $error("Second resistor wrong.");

  property p_cap1;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr && hit_primary && wb_sel_i[0]) |=> ##1 (cap1_sel_o == $past(wb_dat_i[5:3], 2));
  endproperty
  a_cap1: assert property (p_cap1) else $error("Primary capacitor not applied.");

  property p_res1;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr && hit_primary && wb_sel_i[0]) |=> ##1 (res1_sel_o == $past(wb_dat_i[2:0], 2));
  endproperty
  a_res1: assert property (p_res1) else $error("Primary resistor not applied.");

  property p_ohm;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (res1 == 3'h5) |=> (res1_ohm_o == 21'h002710);
  endproperty
  a_ohm: assert property (p_ohm) else $error("Resistor decode wrong.");

  property p_cap;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (cap1 == 3'h1) |=> (cap1_tenth_pf_o == 10'h019);
  endproperty
  a_cap: assert property (p_cap) else $error("Capacitor decode wrong.");

  property p_pin;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      pulse_en_r |=> (conv_done_pin_o == $past(prog_pulse_i));
  endproperty
  a_pin: assert property (p_pin) else $error("Done pin not replaced.");

  property p_rdback;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (req && !wb_we_i && hit_primary) |=> (wb_dat_o[31:6] == 26'h0000000);
  endproperty
  a_rdback: assert property (p_rdback) else $error("Reserved bits read back.");

  property p_led;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (led1 == 6'h3F && dbl) |=> (led1_ua_o == 17'h186A0);
  endproperty
  a_led: assert property (p_led) else $error("LED double scale wrong.");

  property p_led_lin;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (led2 == 6'h01 && !dbl) |=> (led2_ua_o == 17'h00320);
  endproperty
  a_led_lin: assert property (p_led_lin) else $error("LED step wrong.");

  property p_ack_once;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("Acknowledge longer than one cycle.");

  property p_ack_req;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      req |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("Request not acknowledged.");

  property p_cap_shared;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !sep_en |=> (cap2_sel_o == cap1_sel_o);
  endproperty
  a_cap_shared: assert property (p_cap_shared) else $error("Shared capacitor mismatch.");

  property p_led3_field;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr && hit_led && wb_sel_i[2] && wb_sel_i[1]) |=> (led3 == $past(wb_dat_i[17:12]));
  endproperty
  a_led3_field: assert property (p_led3_field) else $error("LED3 field misplaced.");

  property p_led_zero;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (led3 == 6'h00) |=> (led3_ua_o == 17'h00000);
  endproperty
  a_led_zero: assert property (p_led_zero) else $error("LED zero code drives current.");

  property p_split_resv;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr |=> ((split_r & ~tglc_pkg::SPLIT_MASK) == 24'h000000);
  endproperty
  a_split_resv: assert property (p_split_resv) else $error("Reserved split bits stored.");

  property p_pin_done;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !pulse_en_r |=> (conv_done_pin_o == $past(conv_done_i));
  endproperty
  a_pin_done: assert property (p_pin_done) else $error("Done pin not passed through.");

  property p_ohm_top;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (res1 == 3'h7) |=> (res1_ohm_o == 21'h1E8480);
  endproperty
  a_ohm_top: assert property (p_ohm_top) else $error("Top resistor decode wrong.");

  property p_cap_top;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (cap1 == 3'h7) |=> (cap1_tenth_pf_o == 10'h0E1);
  endproperty
  a_cap_top: assert property (p_cap_top) else $error("Top capacitor decode wrong.");

  c_sep: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) sep_en);
  c_pulse: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) pulse_en_r);
  c_dbl: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) dbl && led3 != 6'h00);

endmodule // tglc_regs

/* sim/tb.sv */
`timescale 1ns/10ps
module tb;
  // ==========================================================================
  // Clock, reset and stimulus.
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, cdone = 1'b0, ppulse = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o, rd;
  logic        ack, pin;
  logic [2:0]  r1, r2, c1, c2;
  logic [20:0] ohm;
  logic [9:0]  cap;
  logic [16:0] l1, l2, l3;
  logic [20:0] ohm_tab [8] = '{21'h07A120, 21'h03D090, 21'h0186A0, 21'h00C350,
                               21'h0061A8, 21'h002710, 21'h0F4240, 21'h1E8480};
  logic [9:0]  cap_tab [8] = '{10'h032, 10'h019, 10'h064, 10'h04B,
                               10'h0C8, 10'h0AF, 10'h0FA, 10'h0E1};
  int          failures = 0;
  int          samples_checked = 0;

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  tglc_regs i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .conv_done_i(cdone), .prog_pulse_i(ppulse), .conv_done_pin_o(pin),
    .res1_sel_o(r1), .res2_sel_o(r2), .cap1_sel_o(c1), .cap2_sel_o(c2),
    .res1_ohm_o(ohm), .cap1_tenth_pf_o(cap), .led1_ua_o(l1), .led2_ua_o(l2),
    .led3_ua_o(l3)
  );

  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    check(ohm, 32'h7A120);
    check(cap, 32'h032);
    rdchk(10'h080, 32'h0);
    rdchk(10'h084, 32'h0);
    rdchk(10'h088, 32'h0);
  endtask

  task automatic t_gain_modes();
    bus(10'h080, 1'b1, 32'hFFFFFFFF);
    rdchk(10'h080, 32'h00803F);
    bus(10'h080, 1'b1, 32'h0000002A);
    bus(10'h084, 1'b1, 32'h0000001E);
    settle();
    check({r2, c2, r1, c1}, {3'h6, 3'h3, 3'h6, 3'h3});
    check(ohm, 32'hF4240);
    bus(10'h080, 1'b1, 32'h0000802A);
    settle();
    check({r2, c2, r1, c1}, {3'h2, 3'h5, 3'h6, 3'h3});
    check(c2, 32'h5);
    check(r2, 32'h2);
    check(cap, 32'h04B);
  endtask

  task automatic t_decode();
    for (int i = 0; i < 8; i++) begin
      bus(10'h084, 1'b1, 32'(i * 9));
      settle();
      check(ohm, ohm_tab[i]);
      check(cap, cap_tab[i]);
    end
  endtask

  task automatic t_pulse();
    cdone <= 1'b0; ppulse <= 1'b1;
    bus(10'h084, 1'b1, 32'h00000100);
    rdchk(10'h084, 32'h0);
    settle();
    check(pin, 32'h1);
    cdone <= 1'b1; ppulse <= 1'b0;
    settle();
    check(pin, 32'h0);
    bus(10'h084, 1'b1, 32'h0);
    settle();
    check(pin, 32'h1);
  endtask

  task automatic t_led();
    bus(10'h088, 1'b1, 32'h00FC207F);
    rdchk(10'h088, 32'h00207F);
    settle();
    check(l1, 32'h0C350);
    check(l2, 32'h00320);
    check(l3, 32'h00640);
    bus(10'h08C, 1'b1, 32'h00FFFFFF);
    rdchk(10'h08C, 32'h020000);
    settle();
    check(l1, 32'h186A0);
    check(l2, 32'h00640);
    check(l3, 32'h00C80);
    bus(10'h090, 1'b1, 32'h00FFFFFF);
    rdchk(10'h090, 32'h0);
  endtask

  // ==========================================================================
  // Sequence, watchdog and verdict.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    t_reset();
    t_gain_modes();
    t_decode();
    t_pulse();
    t_led();
    end_of_test();
  end

  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule // tb
